// >>> omme_consts.svh
`ifndef OMME_CONSTS_SVH
`define OMME_CONSTS_SVH

`define OMME_WORD_W 18
`define OMME_BANKS 4
`define OMME_BANK_AW 14
`define OMME_MEM_AW 16
`define OMME_LINE_W 8
`define OMME_ROW_W 7
`define OMME_GRP_W 6
`define OMME_CMD_DEPTH 4

`define OMME_CORE_NS 4
`define OMME_SYS_NS 20
`define OMME_IO_NS 10
`define OMME_SLOT_CYC (`OMME_SYS_NS / `OMME_CORE_NS)
`define OMME_IO_CYC (`OMME_IO_NS / `OMME_CORE_NS)

`endif

// >>> omme_pkg.sv
`include "omme_consts.svh"

package omme_pkg;

  typedef enum logic [1:0] {
    OMME_TAG_NONE = 2'h0,
    OMME_TAG_START = 2'h1,
    OMME_TAG_BODY = 2'h2,
    OMME_TAG_END = 2'h3
  } omme_tag_e;

  typedef struct packed {
    omme_tag_e tag;
    logic [7:0] objNum;
    logic [7:0] colour;
  } omme_word_s;

  typedef enum logic {OMME_OP_MOVE, OMME_OP_END} omme_op_e;

  typedef struct packed {
    omme_op_e op;
    logic [`OMME_LINE_W-1:0] srcX;
    logic [`OMME_ROW_W-1:0] srcLine;
    logic [`OMME_LINE_W-1:0] dstX;
    logic [`OMME_ROW_W-1:0] dstLine;
    logic [7:0] lineCount;
  } omme_cmd_s;

  typedef struct packed {
    logic busy;
    logic [3:0] queued;
    logic [7:0] linesLeft;
    logic [7:0] movesDone;
  } omme_status_s;

  typedef struct packed {
    logic [`OMME_BANKS-1:0] csN;
    logic [`OMME_BANKS-1:0] weN;
    logic oeN;
  } omme_memctl_s;

  typedef enum {OMME_M_IDLE, OMME_M_FETCH, OMME_M_LINE, OMME_M_WAIT, OMME_M_IRQ} omme_mstate_e;

  typedef enum {OMME_I_IDLE, OMME_I_READ, OMME_I_WRITE, OMME_I_DONE} omme_istate_e;

endpackage

// >>> omme_lifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "omme_consts.svh"

module omme_lifo #(
  parameter int W = `OMME_WORD_W,
  parameter int DEPTH = `OMME_BANKS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] din,
  output logic [W-1:0] top,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  logic [W-1:0] ent_r [DEPTH];

  // Shift stack: no random access, so odd-length first and last bursts cost nothing
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge core_clk) begin
      if (srst || clear) begin
        ent_r[i] <= '0;
      end else if (push) begin
        if (i == 0) begin
          ent_r[i] <= din;
        end else begin
          ent_r[i] <= ent_r[(i == 0) ? 0 : i-1];
        end
      end else if (pop) begin
        if (i == DEPTH-1) begin
          ent_r[i] <= '0;
        end else begin
          ent_r[i] <= ent_r[(i == DEPTH-1) ? i : i+1];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || clear) begin
      count <= '0;
    end else if (push) begin
      count <= count + 1'b1;
    end else if (pop) begin
      count <= count - 1'b1;
    end
  end

  assign top = ent_r[0];

endmodule

`default_nettype wire

// >>> omme_engine.sv
// Functional notes
// - Object word is 18 bits: 2 tag bits, 8-bit object number, 8-bit colour.
// - Tag bits decode to start, end, body or non-object word.
// - A line moves contiguously: read from left of start through end word.
// - Write pulses only for object-tagged words, start through end inclusive.
// - Memory is four interleaved 16K banks, accessed in bursts of up to four words.
// - Object address splits into 14-bit bank word address and 2-bit bank.
// - Addresses run consecutively along a line and wrap after 256 words.
// - Upper address bits come from source line on reads, destination on writes.
// - A 6-bit counter counts word groups along the line.
// - Memory control machine drives chip selects and write enables per direction and tag.
// - Address outputs come from registers updated once per system cycle.
// - Chip selects change once per system cycle; write enable registers change twice per system cycle.
// - Four-entry 18-bit stack: filled on read burst, drained on write burst.
// - Stack is last-in first-out so partial bursts need no random access.
// - Write bank order is reversed to match the reversed stack output.
// - Host loads move coordinates of a series of transfers over its own bus.
// - Transfer progress is shown to the host on the command bus.
// - Interrupt is raised when the end-transfer command is processed.
// - Master fetches commands, holds pointers, starts each single-line transfer.
// - Object length counter decrements per line; reaching zero marks last line.
`timescale 1ns/1ps
`default_nettype none
`include "omme_consts.svh"

module omme_engine #(
  parameter int CMD_DEPTH = `OMME_CMD_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire omme_pkg::omme_cmd_s hostCmd,
  input wire logic hostCmdValid,
  output logic hostCmdReady,
  output omme_pkg::omme_status_s hostStatus,
  output logic hostIrq,
  input wire logic hostIrqAck,
  input wire logic memGrant,
  output logic memBusEn,
  output logic [`OMME_BANK_AW-1:0] memAddr,
  output omme_pkg::omme_memctl_s memCtl,
  input wire omme_pkg::omme_word_s memDataIn,
  output omme_pkg::omme_word_s memDataOut,
  output logic memDataOeN
);
  import omme_pkg::*;

  // Depth must be a power of two; the pointers wrap naturally
  localparam int PTR_W = (CMD_DEPTH > 1) ? $clog2(CMD_DEPTH) : 1;
  localparam logic [2:0] PH_LAST = 3'(`OMME_SLOT_CYC - 1);
  localparam logic [2:0] PH_WE_ON = 3'h1;
  localparam logic [2:0] PH_WE_OFF = 3'(1 + `OMME_IO_CYC);

  function automatic logic [`OMME_BANKS-1:0] bankHot(input logic [1:0] b);
    bankHot = 4'h1 << b;
  endfunction

  omme_mstate_e mState_r;
  omme_istate_e iState_r;

  omme_cmd_s cmdQ_r [CMD_DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0] qCount_r;
  logic qPush;
  logic qPop;

  omme_cmd_s cur_r;
  logic [`OMME_ROW_W-1:0] srcLine_r;
  logic [`OMME_ROW_W-1:0] dstLine_r;
  logic [7:0] lenCnt_r;
  logic lastLine_r;
  logic [7:0] movesDone_r;
  logic irq_r;
  logic lineGo;
  logic lineDone;

  logic [2:0] phase_r;
  logic slotEnd;
  logic [`OMME_GRP_W-1:0] grpCnt_r;
  logic [1:0] wIdx_r;
  logic [1:0] firstIdx_r;
  logic endSeen_r;
  logic wrapNext;
  logic inBurst;
  logic [`OMME_LINE_W-1:0] dstX;
  logic [`OMME_MEM_AW-1:0] srcAddr;
  logic [`OMME_MEM_AW-1:0] dstAddr;
  logic [`OMME_MEM_AW-1:0] curAddr;
  logic [1:0] bankSel_r;

  logic lifoPush;
  logic lifoPop;
  logic [`OMME_WORD_W-1:0] lifoTopRaw;
  omme_word_s lifoTop;

  // Host command queue, filled over the host bus while lines are moving
  assign hostCmdReady = (qCount_r != (PTR_W+1)'(CMD_DEPTH));
  assign qPush = hostCmdValid && hostCmdReady;
  assign qPop = (mState_r == OMME_M_FETCH);

  always_ff @(posedge core_clk) begin
    if (qPush) begin
      cmdQ_r[wrPtr_r] <= hostCmd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      qCount_r <= '0;
    end else begin
      if (qPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (qPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      unique case ({qPush, qPop})
        2'b10: qCount_r <= qCount_r + 1'b1;
        2'b01: qCount_r <= qCount_r - 1'b1;
        2'b00, 2'b11: qCount_r <= qCount_r;
      endcase
    end
  end

  // Master control: one command at a time, one line handed down at a time
  assign lineGo = (mState_r == OMME_M_LINE);
  assign lineDone = (iState_r == OMME_I_DONE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mState_r <= OMME_M_IDLE;
    end else begin
      unique case (mState_r)
        OMME_M_IDLE: begin
          // Commands wait until the host has handed over the memory
          if (memGrant && (qCount_r != '0)) begin
            mState_r <= OMME_M_FETCH;
          end
        end
        OMME_M_FETCH: begin
          if (cmdQ_r[rdPtr_r].op == OMME_OP_END) begin
            mState_r <= OMME_M_IRQ;
          end else begin
            mState_r <= OMME_M_LINE;
          end
        end
        OMME_M_LINE: begin
          mState_r <= OMME_M_WAIT;
        end
        OMME_M_WAIT: begin
          if (lineDone) begin
            mState_r <= lastLine_r ? OMME_M_IDLE : OMME_M_LINE;
          end
        end
        OMME_M_IRQ: begin
          mState_r <= OMME_M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_r <= '0;
      srcLine_r <= '0;
      dstLine_r <= '0;
      lenCnt_r <= '0;
      lastLine_r <= 1'b0;
      movesDone_r <= '0;
    end else if (mState_r == OMME_M_FETCH) begin
      cur_r <= cmdQ_r[rdPtr_r];
      srcLine_r <= cmdQ_r[rdPtr_r].srcLine;
      dstLine_r <= cmdQ_r[rdPtr_r].dstLine;
      // A zero count is taken as one line so the counter cannot underflow
      lenCnt_r <= (cmdQ_r[rdPtr_r].lineCount == 8'h00) ? 8'h01 : cmdQ_r[rdPtr_r].lineCount;
    end else if (mState_r == OMME_M_LINE) begin
      lenCnt_r <= lenCnt_r - 8'h01;
      lastLine_r <= (lenCnt_r == 8'h01);
    end else if ((mState_r == OMME_M_WAIT) && lineDone) begin
      srcLine_r <= srcLine_r + 7'h01;
      dstLine_r <= dstLine_r + 7'h01;
      if (lastLine_r) begin
        movesDone_r <= movesDone_r + 8'h01;
      end
    end
  end

  // Set wins over a simultaneous acknowledge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else if (mState_r == OMME_M_IRQ) begin
      irq_r <= 1'b1;
    end else if (hostIrqAck) begin
      irq_r <= 1'b0;
    end
  end

  assign hostIrq = irq_r;
  assign hostStatus.busy = (mState_r != OMME_M_IDLE);
  assign hostStatus.queued = 4'(qCount_r);
  assign hostStatus.linesLeft = lenCnt_r;
  assign hostStatus.movesDone = movesDone_r;

  // Line engine: each word slot is one system cycle of core cycles
  assign inBurst = (iState_r == OMME_I_READ) || (iState_r == OMME_I_WRITE);
  assign slotEnd = (phase_r == PH_LAST);
  assign wrapNext = ((grpCnt_r + 6'h01) == cur_r.srcX[7:2]);
  assign dstX = {grpCnt_r, wIdx_r} - cur_r.srcX + cur_r.dstX;
  assign srcAddr = {1'h0, srcLine_r, grpCnt_r, wIdx_r};
  assign dstAddr = {1'h1, dstLine_r, dstX};
  assign curAddr = (iState_r == OMME_I_WRITE) ? dstAddr : srcAddr;

  always_ff @(posedge core_clk) begin
    if (srst || !inBurst) begin
      phase_r <= '0;
    end else begin
      phase_r <= slotEnd ? 3'h0 : phase_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      iState_r <= OMME_I_IDLE;
      grpCnt_r <= '0;
      wIdx_r <= '0;
      firstIdx_r <= '0;
      endSeen_r <= 1'b0;
    end else begin
      unique case (iState_r)
        OMME_I_IDLE: begin
          if (lineGo) begin
            // Start on the group holding the first word, left of the start word
            grpCnt_r <= cur_r.srcX[7:2];
            wIdx_r <= cur_r.srcX[1:0];
            firstIdx_r <= cur_r.srcX[1:0];
            endSeen_r <= 1'b0;
            iState_r <= OMME_I_READ;
          end
        end
        OMME_I_READ: begin
          if (slotEnd) begin
            // Burst ends at the group boundary or at the end word
            if ((memDataIn.tag == OMME_TAG_END) || (wIdx_r == 2'h3)) begin
              endSeen_r <= (memDataIn.tag == OMME_TAG_END);
              iState_r <= OMME_I_WRITE;
            end else begin
              wIdx_r <= wIdx_r + 2'h1;
            end
          end
        end
        OMME_I_WRITE: begin
          if (slotEnd) begin
            if (wIdx_r == firstIdx_r) begin
              if (endSeen_r || wrapNext) begin
                iState_r <= OMME_I_DONE;
              end else begin
                grpCnt_r <= grpCnt_r + 6'h01;
                wIdx_r <= 2'h0;
                firstIdx_r <= 2'h0;
                iState_r <= OMME_I_READ;
              end
            end else begin
              wIdx_r <= wIdx_r - 2'h1;
            end
          end
        end
        OMME_I_DONE: begin
          iState_r <= OMME_I_IDLE;
        end
      endcase
    end
  end

  assign lifoPush = (iState_r == OMME_I_READ) && slotEnd;
  assign lifoPop = (iState_r == OMME_I_WRITE) && slotEnd;
  assign lifoTop = omme_word_s'(lifoTopRaw);

  omme_lifo #(
    .W(`OMME_WORD_W),
    .DEPTH(`OMME_BANKS)
  ) u_stack (
    .core_clk(core_clk),
    .srst(srst),
    .clear(lineGo),
    .push(lifoPush),
    .pop(lifoPop),
    .din(memDataIn),
    .top(lifoTopRaw),
    .count()
  );

  // Address and write data change only at a slot start
  always_ff @(posedge core_clk) begin
    if (srst) begin
      memAddr <= '0;
      bankSel_r <= '0;
      memDataOut <= '0;
    end else if (inBurst && (phase_r == 3'h0)) begin
      memAddr <= curAddr[`OMME_MEM_AW-1:2];
      bankSel_r <= curAddr[1:0];
      if (iState_r == OMME_I_WRITE) begin
        memDataOut <= lifoTop;
      end
    end
  end

  // Controls are re-registered mid-slot, giving the write pulse its own edges
  always_ff @(posedge core_clk) begin
    if (srst) begin
      memBusEn <= 1'b0;
      memCtl <= '1;
      memDataOeN <= 1'b1;
    end else begin
      memBusEn <= memGrant;
      if (!memGrant || !inBurst) begin
        memCtl <= '1;
        memDataOeN <= 1'b1;
      end else begin
        if (phase_r == 3'h0) begin
          memCtl.csN <= ~bankHot(curAddr[1:0]);
          memCtl.oeN <= (iState_r != OMME_I_READ);
          memDataOeN <= (iState_r != OMME_I_WRITE);
        end
        if ((iState_r == OMME_I_WRITE) && (phase_r == PH_WE_ON) &&
            (memDataOut.tag != OMME_TAG_NONE)) begin
          memCtl.weN <= ~bankHot(bankSel_r);
        end else if (phase_r == PH_WE_OFF) begin
          memCtl.weN <= '1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> omme_engine_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "omme_consts.svh"
module omme_engine_checker
  import omme_pkg::*;
#(
  parameter int CMD_DEPTH = `OMME_CMD_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hostCmdValid,
  input wire logic hostCmdReady,
  input wire omme_pkg::omme_status_s hostStatus,
  input wire logic hostIrq,
  input wire logic hostIrqAck,
  input wire logic memGrant,
  input wire logic memBusEn,
  input wire logic [`OMME_BANK_AW-1:0] memAddr,
  input wire omme_pkg::omme_memctl_s memCtl,
  input wire omme_pkg::omme_word_s memDataOut,
  input wire logic memDataOeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_reset_quiet: assert property ($fell(srst) |-> &memCtl.csN && &memCtl.weN && memCtl.oeN
    && memDataOeN && !memBusEn && !hostIrq && hostStatus.queued == 4'h0)
    else $error("outputs not idle after reset");
  a_grant_gate: assert property (!memGrant[*2] |-> &memCtl.csN && &memCtl.weN && !memBusEn)
    else $error("memory driven without grant");
  a_cs_onehot: assert property (!(&memCtl.csN) |-> $onehot(~memCtl.csN))
    else $error("more than one bank selected");
  a_we_pulse: assert property ($fell(&memCtl.weN) |=> !(&memCtl.weN) ##1 (&memCtl.weN))
    else $error("write strobe not two cycles");
  a_we_cs: assert property (!(&memCtl.weN) |-> ((~memCtl.weN & memCtl.csN) == 4'h0)
    && !memDataOeN) else $error("write strobe without select or data drive");
  a_we_tag: assert property (!(&memCtl.weN) |-> memDataOut.tag != OMME_TAG_NONE)
    else $error("non-object word written");
  a_read_nodrive: assert property (!memCtl.oeN |-> memDataOeN && &memCtl.weN)
    else $error("data driven during read");
  a_addr_hold: assert property ($changed(memAddr) |=> $stable(memAddr) [*3])
    else $error("address changed inside a slot");
  a_full_refuse: assert property (hostStatus.queued == CMD_DEPTH |-> !hostCmdReady)
    else $error("full queue accepts commands");
  a_push_seen: assert property (hostCmdValid && hostCmdReady |=> hostStatus.queued != '0)
    else $error("accepted command not queued");
  a_irq_hold: assert property (hostIrq && !hostIrqAck |=> hostIrq)
    else $error("interrupt dropped without ack");
  a_irq_clear: assert property (hostIrq && hostIrqAck && !hostStatus.busy |=> !hostIrq)
    else $error("interrupt not cleared by ack");
endmodule
`default_nettype wire

// >>> omme_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "omme_consts.svh"
module omme_mem_model
  import omme_pkg::*;
(
  input wire logic core_clk,
  input wire logic [`OMME_BANK_AW-1:0] memAddr,
  input wire omme_pkg::omme_memctl_s memCtl,
  input wire omme_pkg::omme_word_s memDataOut,
  output omme_pkg::omme_word_s memDataIn
);
  omme_word_s mem [0:65535];
  logic [17:0] floatWord_r = 18'h2_5a3c;
  logic [1:0] bank;
  always_comb begin
    bank = 2'h0;
    for (int b = 0; b < 4; b++) begin
      if (!memCtl.csN[b]) begin
        bank = 2'(b);
      end
    end
  end
  // Released bus toggles every cycle so stale data never passes as a read
  assign memDataIn = (!(&memCtl.csN) && !memCtl.oeN) ? mem[{memAddr, bank}] :
    omme_word_s'(floatWord_r);
  // Plain always: the bench preloads this array directly between runs
  always @(posedge core_clk) begin
    floatWord_r <= ~floatWord_r;
    for (int b = 0; b < 4; b++) begin
      if (!memCtl.weN[b] && !memCtl.csN[b]) begin
        mem[{memAddr, 2'(b)}] <= memDataOut;
      end
    end
  end
endmodule
`default_nettype wire

// >>> omme_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "omme_consts.svh"
module omme_engine_tb;
  import omme_pkg::*;
  localparam int CMD_DEPTH = `OMME_CMD_DEPTH;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  omme_cmd_s hostCmd = '0;
  logic hostCmdValid = 1'h0;
  logic hostCmdReady;
  omme_status_s hostStatus;
  logic hostIrq;
  logic hostIrqAck = 1'h0;
  logic memGrant = 1'h0;
  logic memBusEn;
  logic [`OMME_BANK_AW-1:0] memAddr;
  omme_memctl_s memCtl;
  omme_word_s memDataIn;
  omme_word_s memDataOut;
  logic memDataOeN;
  omme_word_s refMem [0:65535];
  omme_cmd_s cmds [4];
  int errors = 0;
  int totalChecks = 0;

  always #2 core_clk = ~core_clk;

  omme_engine #(.CMD_DEPTH(CMD_DEPTH)) dut (.core_clk(core_clk), .srst(srst),
    .hostCmd(hostCmd), .hostCmdValid(hostCmdValid), .hostCmdReady(hostCmdReady),
    .hostStatus(hostStatus), .hostIrq(hostIrq), .hostIrqAck(hostIrqAck),
    .memGrant(memGrant), .memBusEn(memBusEn), .memAddr(memAddr), .memCtl(memCtl),
    .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOeN(memDataOeN));
  omme_mem_model mdl (.core_clk(core_clk), .memAddr(memAddr), .memCtl(memCtl),
    .memDataOut(memDataOut), .memDataIn(memDataIn));

  task automatic check(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input omme_cmd_s c);
    hostCmd = c;
    hostCmdValid = 1'h1;
    while (hostCmdReady !== 1'h1) tick(1);
    tick(1);
    hostCmdValid = 1'h0;
    tick(1);
  endtask

  function automatic logic [15:0] adr(input logic dst, input logic [6:0] ln,
                                      input logic [7:0] x);
    return {dst, ln, x};
  endfunction

  // Object line: blanks from srcX, start, optional body, end, then junk
  task automatic mk_line(input logic [6:0] ln, input int sx, input int body);
    int st;
    omme_word_s w;
    st = sx + $urandom % 3;
    for (int x = sx; x < 256; x++) begin
      w = omme_word_s'(18'($urandom));
      if (x < st) w.tag = OMME_TAG_NONE;
      else if (x == st) w.tag = OMME_TAG_START;
      else if (x <= st + body) w.tag = w.tag[0] ? OMME_TAG_NONE : OMME_TAG_BODY;
      else if (x == st + body + 1) w.tag = OMME_TAG_END;
      refMem[adr(1'h0, ln, 8'(x))] = w;
    end
  endtask

  task automatic apply(input omme_cmd_s c);
    int n;
    omme_word_s w;
    n = (c.lineCount == 8'h0) ? 1 : int'(c.lineCount);
    for (int j = 0; j < n; j++) begin
      for (int x = c.srcX; x < 256; x++) begin
        w = refMem[adr(1'h0, c.srcLine + 7'(j), 8'(x))];
        if (w.tag != OMME_TAG_NONE)
          refMem[adr(1'h1, c.dstLine + 7'(j), 8'(x) - c.srcX + c.dstX)] = w;
        if (w.tag == OMME_TAG_END) break;
      end
    end
  endtask

  task automatic run_round(input int r);
    int n;
    int bad;
    memGrant = 1'h0; // engine kept off memory while image loads
    srst = 1'h1;
    tick(r == 0 ? 20 : 3);
    srst = 1'h0;
    tick(1);
    check(hostStatus === '0 && hostCmdReady === 1'h1, "status after reset");
    for (int a = 0; a < 65536; a++) refMem[a] = omme_word_s'(18'($urandom));
    for (int m = 0; m < 4; m++) begin
      cmds[m] = '{OMME_OP_MOVE, 8'($urandom % 200), 7'(m * 32 + r * 8), 8'($urandom),
        7'($urandom), (m == 0) ? 8'h0 : 8'(1 + $urandom % 3)};
      n = (m == 0) ? 1 : int'(cmds[m].lineCount);
      for (int j = 0; j < n; j++)
        mk_line(cmds[m].srcLine + 7'(j), cmds[m].srcX, (m == 0) ? 0 : $urandom % 8);
    end
    for (int a = 0; a < 65536; a++) mdl.mem[a] = refMem[a];
    for (int m = 0; m < 4; m++) apply(cmds[m]);
    for (int m = 0; m < 4; m++) send(cmds[m]);
    check(!hostCmdReady && hostStatus.queued === 4'(CMD_DEPTH), "queue full");
    check(memBusEn === 1'h0 && memCtl.csN === 4'hf, "bus used without grant");
    memGrant = 1'h1; // requests loaded, memory handed over
    // Second round holds the acknowledge high: the end interrupt must still win
    hostIrqAck = 1'(r);
    send(omme_cmd_s'{OMME_OP_END, 8'h0, 7'h0, 8'h0, 7'h0, 8'h0});
    for (int i = 0; i < 20000 && hostIrq !== 1'h1; i++) tick(1);
    check(hostIrq === 1'h1 && hostStatus.movesDone === 8'h4, "end interrupt");
    bad = 0;
    for (int a = 32768; a < 65536; a++) if (mdl.mem[a] !== refMem[a]) bad++;
    check(bad == 0, "final image differs");
    hostIrqAck = 1'h1;
    tick(1);
    hostIrqAck = 1'h0;
    tick(1);
    check(hostIrq === 1'h0 && hostStatus.busy === 1'h0, "interrupt not cleared");
    memGrant = 1'h0;
    tick(2);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9671));
    run_round(0);
    run_round(1);
    wrap_up;
  end

  initial begin
    #380000;
    errors++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up;
  end
endmodule

bind omme_engine omme_engine_checker #(.CMD_DEPTH(CMD_DEPTH)) chk (.core_clk(core_clk),
  .srst(srst), .hostCmdValid(hostCmdValid), .hostCmdReady(hostCmdReady),
  .hostStatus(hostStatus), .hostIrq(hostIrq), .hostIrqAck(hostIrqAck),
  .memGrant(memGrant), .memBusEn(memBusEn), .memAddr(memAddr), .memCtl(memCtl),
  .memDataOut(memDataOut), .memDataOeN(memDataOeN));
`default_nettype wire
